// ---- pkg/spi_frame_pkg.sv ----
// Contract
// - Sensor value captured at chip select fall
// - Response: echo, status, value, options, detail, CRC
// - Wide mode puts low bits in options
// - Six reserved nibbles answered next frame
// - Reserved answer upper bits undefined, CRC valid
// - Command CRC over 32 bits, MSB first
// - Bad command CRC gives error response
// - Checker seeds, shifts all, expects zero
// - Polynomial x8+x5+x3+x2+x+1, LSB shift-in
// - Seed FF, or F and nibble
// - Every response carries CRC, same rules
// - Payload then eight zeros yields CRC
// - Sensor answer comes in next frame
// - Status codes, internal error wins
package spi_frame_pkg;

    localparam logic [7:0] CRC_POLY     = 8'h2f;
    localparam logic [7:0] SEED_DEFAULT = 8'hff;
    localparam logic [3:0] SEED_UPPER   = 4'hf;
    localparam logic [5:0] FRAME_BITS   = 6'h20;
    localparam logic [4:0] TX_FIRST     = 5'h1f;
    localparam logic [5:0] PAYLOAD_LEN  = 6'h18;
    localparam logic [5:0] CALC_LAST    = 6'h1f;
    localparam logic [5:0] CNT_MAX      = 6'h3f;

    localparam int ECHO_HI = 31;
    localparam int ST_HI   = 27;
    localparam int SD_HI   = 25;
    localparam int OPT_HI  = 13;
    localparam int SF_HI   = 9;
    localparam int CRC_HI  = 7;

    localparam logic [3:0] RSV_A = 4'h0;
    localparam logic [3:0] RSV_B = 4'h2;
    localparam logic [3:0] RSV_C = 4'h4;
    localparam logic [3:0] RSV_D = 4'h6;
    localparam logic [3:0] RSV_E = 4'ha;
    localparam logic [3:0] RSV_F = 4'he;

    localparam logic [1:0] ST_INIT     = 2'h0;
    localparam logic [1:0] ST_NORMAL   = 2'h1;
    localparam logic [1:0] ST_SELFTEST = 2'h2;
    localparam logic [1:0] ST_INTERR   = 2'h3;
    localparam logic [1:0] SF_SPI_ERR  = 2'h3;

    typedef enum logic [2:0] {
        KIND_NONE   = 3'b000,
        KIND_SENSOR = 3'b001,
        KIND_RSV    = 3'b010,
        KIND_EXT    = 3'b011,
        KIND_ERR    = 3'b100
    } kind_e;

    typedef struct packed {
        logic       int_err;
        logic       self_test;
        logic       init_done;
        logic [1:0] detail;
    } status_s;

    typedef struct packed {
        logic [2:0]  sync_cs;
        logic [2:0]  sync_ck;
        logic [2:0]  sync_di;
        logic        cs_f;
        logic        ck_f;
        logic        active;
        logic        bad;
        logic [5:0]  cnt;
        logic [31:0] rx_sh;
        logic [7:0]  rx_crc;
        logic [4:0]  tx_idx;
        logic [31:0] resp;
        logic        miso;
        logic        calc_busy;
        logic [5:0]  calc_cnt;
        logic [7:0]  calc_crc;
        kind_e       pend_kind;
        logic [3:0]  pend_nib;
        logic [1:0]  pend_st;
        logic [1:0]  pend_sf;
        logic [2:0]  src_sel;
        logic [31:0] cmd_word;
        logic        cmd_stb;
        logic        crc_err;
        logic        frame_err;
    } state_s;

    localparam state_s STATE_RST = '{sync_cs: 3'h7, sync_ck: 3'h0, sync_di: 3'h0, cs_f: 1'b1, ck_f: 1'b0,
        active: 1'b0, bad: 1'b0, cnt: 6'h00, rx_sh: 32'h0000_0000, rx_crc: 8'h00, tx_idx: 5'h1f,
        resp: 32'h0000_0000, miso: 1'b0, calc_busy: 1'b0, calc_cnt: 6'h00, calc_crc: 8'h00,
        pend_kind: KIND_NONE, pend_nib: 4'h0, pend_st: 2'h0, pend_sf: 2'h0, src_sel: 3'h0,
        cmd_word: 32'h0000_0000, cmd_stb: 1'b0, crc_err: 1'b0, frame_err: 1'b0};

endpackage : spi_frame_pkg

// ---- logic/crc8_step.sv ----
`timescale 1ns/100ps
module crc8_step (
    input  wire logic [7:0] crc_i,
    input  wire logic       bit_i,
    output logic      [7:0] crc_o
);
    // Bit enters at the low end, top bit folds back through the polynomial
    assign crc_o = {crc_i[6:0], bit_i} ^ (crc_i[7] ? spi_frame_pkg::CRC_POLY : 8'h00);
endmodule : crc8_step

// ---- logic/spi_sensor_frame.sv ----
`timescale 1ns/100ps
module spi_sensor_frame (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   sclk_i,
    input  wire logic                   mosi_i,
    output logic                        miso_o,
    output logic                        miso_oe_o,
    input  wire logic [3:0]             crc_seed_nibble_i,
    input  wire logic                   wide_mode_i,
    input  wire logic [15:0]            sensor_value_i,
    input  wire spi_frame_pkg::status_s status_i,
    input  wire logic                   miso_err_i,
    input  wire logic [23:0]            ext_resp_i,
    output logic [2:0]                  source_selector_o,
    output logic [31:0]                 cmd_word_o,
    output logic                        cmd_strobe_o,
    output logic                        crc_err_o,
    output logic                        frame_err_o
);
    spi_frame_pkg::state_s s;
    spi_frame_pkg::state_s n;
    logic [7:0]  seed;
    logic [7:0]  rx_step;
    logic [7:0]  tx_step;
    logic        calc_bit;
    logic        cs_fall;
    logic        cs_rise;
    logic        ck_rise;
    logic        ck_fall;
    logic [11:0] sd_field;
    logic [3:0]  opt_field;
    logic [1:0]  st_now;
    logic        rsv_nib;
    logic        cmd_ok;

    assign seed = (crc_seed_nibble_i == 4'h0) ? spi_frame_pkg::SEED_DEFAULT
                                              : {spi_frame_pkg::SEED_UPPER, crc_seed_nibble_i};

    // Edges count only once second and third stage agree
    assign cs_fall = s.cs_f & ~s.sync_cs[1] & ~s.sync_cs[2];
    assign cs_rise = ~s.cs_f & s.sync_cs[1] & s.sync_cs[2];
    assign ck_rise = ~s.ck_f & s.sync_ck[1] & s.sync_ck[2];
    assign ck_fall = s.ck_f & ~s.sync_ck[1] & ~s.sync_ck[2];

    crc8_step rx_crc_u (
        .crc_i (s.rx_crc),
        .bit_i (s.sync_di[2]),
        .crc_o (rx_step)
    );

    // Payload bits first, then zeros while calc_cnt passes the payload
    assign calc_bit = (s.calc_cnt < spi_frame_pkg::PAYLOAD_LEN) ?
                      s.resp[spi_frame_pkg::TX_FIRST - s.calc_cnt[4:0]] : 1'b0;

    crc8_step tx_crc_u (
        .crc_i (s.calc_crc),
        .bit_i (calc_bit),
        .crc_o (tx_step)
    );

    assign sd_field  = wide_mode_i ? sensor_value_i[15:4] : sensor_value_i[11:0];
    assign opt_field = wide_mode_i ? sensor_value_i[3:0] : 4'h0;

    always_comb begin
        if (status_i.int_err) begin
            st_now = spi_frame_pkg::ST_INTERR;
        end else if (status_i.self_test) begin
            st_now = spi_frame_pkg::ST_SELFTEST;
        end else if (!status_i.init_done) begin
            st_now = spi_frame_pkg::ST_INIT;
        end else begin
            st_now = spi_frame_pkg::ST_NORMAL;
        end
    end

    always_comb begin
        case (s.rx_sh[31:28])
            spi_frame_pkg::RSV_A, spi_frame_pkg::RSV_B, spi_frame_pkg::RSV_C,
            spi_frame_pkg::RSV_D, spi_frame_pkg::RSV_E, spi_frame_pkg::RSV_F: rsv_nib = 1'b1;
            default: rsv_nib = 1'b0;
        endcase
    end

    // Frame must be 32 clean edges with sclk low at both chip select edges
    assign cmd_ok = ~s.bad & ~s.ck_f & (s.cnt == spi_frame_pkg::FRAME_BITS) & (s.rx_crc == 8'h00);

    always_comb begin
        n = s;
        n.cmd_stb   = 1'b0;
        n.crc_err   = 1'b0;
        n.frame_err = 1'b0;
        n.sync_cs = {s.sync_cs[1:0], cs_n_i};
        n.sync_ck = {s.sync_ck[1:0], sclk_i};
        n.sync_di = {s.sync_di[1:0], mosi_i};
        if (s.sync_cs[1] == s.sync_cs[2]) begin
            n.cs_f = s.sync_cs[2];
        end
        if (s.sync_ck[1] == s.sync_ck[2]) begin
            n.ck_f = s.sync_ck[2];
        end
        if (s.calc_busy) begin
            n.calc_crc = tx_step;
            n.calc_cnt = s.calc_cnt + 6'h01;
            if (s.calc_cnt == spi_frame_pkg::CALC_LAST) begin
                n.resp[spi_frame_pkg::CRC_HI -: 8] = tx_step;
                n.calc_busy = 1'b0;
            end
        end
        if (cs_fall) begin
            n.active    = 1'b1;
            n.bad       = s.ck_f;
            n.cnt       = 6'h00;
            n.rx_crc    = seed;
            n.tx_idx    = spi_frame_pkg::TX_FIRST;
            n.calc_busy = 1'b1;
            n.calc_cnt  = 6'h00;
            n.calc_crc  = seed;
            case (s.pend_kind)
                spi_frame_pkg::KIND_SENSOR: n.resp = {s.pend_nib, s.pend_st, sd_field, opt_field,
                                                      s.pend_sf, 8'h00};
                spi_frame_pkg::KIND_ERR:    n.resp = {s.pend_nib, spi_frame_pkg::ST_INTERR, 16'h0000,
                                                      spi_frame_pkg::SF_SPI_ERR, 8'h00};
                spi_frame_pkg::KIND_EXT:    n.resp = {ext_resp_i, 8'h00};
                default:                    n.resp = 32'h0000_0000;
            endcase
        end else if (s.active && ck_rise) begin
            if (s.cnt != spi_frame_pkg::CNT_MAX) begin
                n.cnt = s.cnt + 6'h01;
            end
            n.rx_sh  = {s.rx_sh[30:0], s.sync_di[2]};
            n.rx_crc = rx_step;
        end else if (s.active && ck_fall && s.tx_idx != 5'h00) begin
            n.tx_idx = s.tx_idx - 5'h01;
        end
        if (cs_rise && s.active) begin
            n.active  = 1'b0;
            n.pend_nib = s.rx_sh[31:28];
            n.pend_st = st_now;
            n.pend_sf = status_i.detail;
            if (!cmd_ok || miso_err_i) begin
                n.pend_kind = spi_frame_pkg::KIND_ERR;
                n.crc_err   = (s.rx_crc != 8'h00);
                n.frame_err = s.bad | s.ck_f | (s.cnt != spi_frame_pkg::FRAME_BITS);
            end else begin
                n.cmd_stb  = 1'b1;
                n.cmd_word = s.rx_sh;
                if (s.rx_sh[28]) begin
                    n.pend_kind = spi_frame_pkg::KIND_SENSOR;
                    n.src_sel   = s.rx_sh[31:29];
                end else if (rsv_nib) begin
                    n.pend_kind = spi_frame_pkg::KIND_RSV;
                end else begin
                    n.pend_kind = spi_frame_pkg::KIND_EXT;
                end
            end
        end
        n.miso = n.resp[n.tx_idx];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= spi_frame_pkg::STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign miso_o            = s.miso;
    assign miso_oe_o         = s.active;
    assign source_selector_o = s.src_sel;
    assign cmd_word_o        = s.cmd_word;
    assign cmd_strobe_o      = s.cmd_stb;
    assign crc_err_o         = s.crc_err;
    assign frame_err_o       = s.frame_err;

    // Reference model for checking only
    function automatic logic [7:0] ref_crc(input logic [7:0] sd, input logic [23:0] pl);
        logic [7:0]  c;
        logic [31:0] m;
        c = sd;
        m = {pl, 8'h00};
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], m[i]} ^ (c[7] ? spi_frame_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : ref_crc

    localparam int SD_HI_C = spi_frame_pkg::SD_HI;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence fall_sensor_s;
        cs_fall && s.pend_kind == spi_frame_pkg::KIND_SENSOR;
    endsequence
    sequence good_rise_s;
        cs_rise && s.active && cmd_ok && !miso_err_i;
    endsequence

    sensor_capture_a: assert property (fall_sensor_s |=> s.resp[SD_HI_C -: 12] == $past(sd_field))
        else $error("sensor field not captured at select fall");
    frame_layout_a: assert property (fall_sensor_s |=> s.resp[31:26] == $past({s.pend_nib, s.pend_st}))
        else $error("echo or status misplaced");
    wide_option_a: assert property (fall_sensor_s and wide_mode_i |=>
        s.resp[13:10] == $past(sensor_value_i[3:0]))
        else $error("option bits wrong in wide mode");
    reserved_kind_a: assert property (good_rise_s and !s.rx_sh[28] and rsv_nib |=>
        s.pend_kind == spi_frame_pkg::KIND_RSV)
        else $error("reserved command not queued");
    crc_reject_a: assert property (cs_rise && s.active && s.rx_crc != 8'h00 |=>
        s.pend_kind == spi_frame_pkg::KIND_ERR && crc_err_o && !cmd_strobe_o)
        else $error("bad CRC not rejected");
    seed_load_a: assert property (cs_fall |=> s.rx_crc == $past(seed) && s.calc_crc == $past(seed))
        else $error("seed not loaded");
    resp_crc_a: assert property ($fell(s.calc_busy) && !$past(cs_fall) |->
        s.resp[7:0] == ref_crc(seed, s.resp[31:8]))
        else $error("response CRC mismatch");
    calc_time_a: assert property (cs_fall |=> s.calc_busy [*8] ##[1:30] !s.calc_busy)
        else $error("response CRC not finished in time");
    next_frame_a: assert property (good_rise_s and s.rx_sh[28] |=>
        s.pend_kind == spi_frame_pkg::KIND_SENSOR && s.src_sel == $past(s.rx_sh[31:29]))
        else $error("sensor request not queued for next frame");
    status_prio_a: assert property (cs_rise && s.active && status_i.int_err |=>
        s.pend_st == spi_frame_pkg::ST_INTERR)
        else $error("internal error lost priority");

endmodule : spi_sensor_frame

// ---- verification/host_spi_model.sv ----
`timescale 1ns/100ps
module host_spi_model (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    int slow = 0;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // Mode 0, MSB first, 8 clocks per link period; sclk rests low between frames
    task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [31:0] resp);
        resp = 32'h0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        wait_clk(8 + slow);
        for (int i = 0; i < nbits; i++) begin
            mosi_o <= (i < 32) ? cmd[31-i] : 1'b0;
            wait_clk(4);
            sclk_o <= 1'b1;
            wait_clk(4);
            // Sampled at the fall, while the bit still stands; extra clocks only repeat bit 0
            if (i < 32) resp[31-i] = miso_i;
            sclk_o <= 1'b0;
        end
        // Released line must not keep its last bit
        mosi_o <= ~mosi_o;
        wait_clk(4 + slow);
        cs_n_o <= 1'b1;
        wait_clk(10);
    endtask : xfer
endmodule : host_spi_model

// ---- verification/tb_spi_sensor_frame.sv ----
`timescale 1ns/100ps
module tb_spi_sensor_frame;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic [3:0]             crc_seed_nibble_i = 4'h0;
    logic                   wide_mode_i = 1'b0;
    logic [15:0]            sensor_value_i = 16'h0000;
    spi_frame_pkg::status_s status_i = '0;
    logic                   miso_err_i = 1'b0;
    logic [23:0]            ext_resp_i = 24'h000000;
    logic                   cs_n, sclk, mosi, miso_o, miso_oe_o, miso_last = 1'b0;
    wire                    miso_w = miso_oe_o ? miso_o : ~miso_last;
    logic [2:0]             source_selector_o;
    logic [31:0]            cmd_word_o, cmd, resp, exp_w, mask;
    logic                   cmd_strobe_o, crc_err_o, frame_err_o, bad, merr, ok, wd, pnk;
    logic [3:0]             nib, sn, pn;
    logic [1:0]             pst, psf;
    logic [7:0]             crcm;
    logic [15:0]            sv;
    spi_frame_pkg::status_s st_v;
    int n_fail = 0, n_compared = 0, n_stb = 0, n_crc = 0, n_frm = 0, cycles = 0;
    int seed = 32'he1f02b99, nbits, pk, stb0, crc0, frm0;

    spi_sensor_frame dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o), .crc_seed_nibble_i(crc_seed_nibble_i),
        .wide_mode_i(wide_mode_i), .sensor_value_i(sensor_value_i), .status_i(status_i),
        .miso_err_i(miso_err_i), .ext_resp_i(ext_resp_i), .source_selector_o(source_selector_o),
        .cmd_word_o(cmd_word_o), .cmd_strobe_o(cmd_strobe_o), .crc_err_o(crc_err_o), .frame_err_o(frame_err_o));
    host_spi_model host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso_w));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (miso_oe_o) miso_last <= miso_o;
        if (cmd_strobe_o === 1'b1) n_stb++;
        if (crc_err_o === 1'b1) n_crc++;
        if (frame_err_o === 1'b1) n_frm++;
        if (cycles == 40000) begin
            n_fail++;
            wrap_up();
        end
    end

    function automatic logic [7:0] seed_of(logic [3:0] n);
        return (n == 4'h0) ? 8'hff : {4'hf, n};
    endfunction : seed_of

    function automatic logic [7:0] crc_of(logic [3:0] n, logic [31:0] w);
        logic [7:0] c;
        c = seed_of(n);
        for (int i = 31; i >= 0; i--) begin  // Bits 31..8, then eight zeros
            c = {c[6:0], (i > 7) ? w[i] : 1'b0} ^ (c[7] ? spi_frame_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc_of

    function automatic logic [1:0] st_of(spi_frame_pkg::status_s s);
        if (s.int_err) return 2'h3;
        if (s.self_test) return 2'h2;
        return s.init_done ? 2'h1 : 2'h0;
    endfunction : st_of

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        pk = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        ext_resp_i <= 24'($random(seed));
        repeat (6) @(posedge clk_i);
        for (int k = 0; k < 100; k++) begin
            // First sixteen frames walk every command nibble
            nib = (k < 16) ? 4'(k) : 4'($random(seed));
            bad = (k >= 16) && (($random(seed) & 7) == 0);
            merr = (k >= 16) && (($random(seed) & 15) == 1);
            nbits = ((k >= 16) && (($random(seed) & 15) == 2)) ? ((($random(seed) & 1) != 0) ? 31 : 33) : 32;
            sn = 4'($random(seed));
            sv = 16'($random(seed));
            wd = 1'($random(seed));
            st_v = 5'($random(seed));
            host.slow = (k % 5 == 0) ? 6 : 0;
            cmd = {nib, nib[0] ? 20'h0 : 20'($random(seed)), 8'h00};  // Sensor request body zeros, other bodies random
            cmd[7:0] = crc_of(sn, cmd) ^ (bad ? {7'($random(seed)), 1'b1} : 8'h00);
            @(posedge clk_i);
            crc_seed_nibble_i <= sn;
            sensor_value_i <= sv;
            wide_mode_i <= wd;
            status_i <= st_v;
            miso_err_i <= merr;
            mask = (pk == 2) ? 32'h0 : (pk == 4 && !pnk) ? 32'h0fffff00 : 32'hffffff00;
            case (pk)
                1: exp_w = {pn, pst, wd ? sv[15:4] : sv[11:0], wd ? sv[3:0] : 4'h0, psf, 8'h00};
                3: exp_w = {ext_resp_i, 8'h00};
                4: exp_w = {pn, 2'h3, 16'h0000, 2'h3, 8'h00};
                default: exp_w = 32'h0;
            endcase
            stb0 = n_stb;
            crc0 = n_crc;
            frm0 = n_frm;
            fork
                host.xfer(cmd, nbits, resp);
                begin
                    // Late change after the select fall must not reach this answer
                    repeat (40) @(posedge clk_i);
                    sensor_value_i <= ~sv;
                end
            join
            check("response", resp & mask, exp_w & mask);
            // A short frame never clocks out bit 0
            crcm = {7'h00, nbits < 32};
            check("response crc", 32'(resp[7:0] | crcm), 32'(crc_of(sn, resp) | crcm));
            ok = (nbits == 32) && !bad && !merr;
            check("strobe count", 32'(n_stb - stb0), 32'(ok));
            check("frame error count", 32'(n_frm - frm0), 32'(nbits != 32));
            if (nbits == 32) check("crc error count", 32'(n_crc - crc0), 32'(bad));
            if (ok) check("command word", cmd_word_o, cmd);
            if (ok && nib[0]) check("source", 32'(source_selector_o), 32'(nib[3:1]));
            pn = nib;
            pnk = (nbits == 32);
            pst = st_of(st_v);
            psf = st_v.detail;
            pk = !ok ? 4 : nib[0] ? 1 : (nib inside {4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he}) ? 2 : 3;
        end
        wrap_up();
    end
endmodule : tb_spi_sensor_frame
